// ---- pkg/apc_pkg.sv ----
// What this block does
// - Start loads target; each output pulse decrements.
// - Hold positioning count until position-change-start input.
// - Command counter: 32 bits, output pulses only.
// - Mechanical, general 32 bits; deflection 16 bits.
// - Mechanical source: 00 encoder, 01 output, 10 pulser.
// - Deflection pairs: out/enc, out/pulser, enc/pulser.
// - General source: output, encoder, pulser, half clock.
// - Quadrature: A leading up, B leading down.
// - Two-pulse: A rising up, B falling down.
// - Direction reversal for encoder and pulser pairs.
// - Both phases changing together flags error interrupt.
// - Pulser source is decoded internal signal, not pins.
// - Mode codes: 1x, 2x, 4x, two-pulse.
// - Filter drops pulses under three clock cycles.
package apc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ALIGN_MASK = 8'hFC;
  localparam logic [7:0] OFF_TARGET = 8'h00;
  localparam logic [7:0] OFF_AXIS_MODE = 8'h04;
  localparam logic [7:0] OFF_SRC_ENV = 8'h08;
  localparam logic [7:0] OFF_INM_ENV = 8'h0C;
  localparam logic [7:0] OFF_POS = 8'h10;
  localparam logic [7:0] OFF_CMD = 8'h14;
  localparam logic [7:0] OFF_MECH = 8'h18;
  localparam logic [7:0] OFF_DEFL = 8'h1C;
  localparam logic [7:0] OFF_GP = 8'h20;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h28;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [31:0] MODE_MASK = 32'h00004000;
  localparam logic [31:0] SRC_ENV_MASK = 32'h00003F00;
  localparam logic [31:0] INM_MASK = 32'hC77F0000;
  localparam int unsigned BIT_PCS_EN = 14;
  localparam int unsigned CI2_LSB = 8;
  localparam int unsigned CI3_LSB = 10;
  localparam int unsigned CI4_LSB = 12;
  localparam int unsigned ERR_EN_ENC = 16;
  localparam int unsigned ERR_EN_PUL = 17;
  localparam int unsigned FILT_ENC = 18;
  localparam int unsigned FILT_PUL = 19;
  localparam int unsigned MODE_ENC_LSB = 20;
  localparam int unsigned REV_ENC = 22;
  localparam int unsigned MODE_PUL_LSB = 24;
  localparam int unsigned REV_PUL = 26;
  localparam int unsigned OFF_ENC_BIT = 30;
  localparam int unsigned OFF_PUL_BIT = 31;
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_ENC_ERR = 0;
  localparam int unsigned IRQ_PUL_ERR = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned FILT_CYCLES = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IN_QUAD1 = 2'b00,
    IN_QUAD2 = 2'b01,
    IN_QUAD4 = 2'b10,
    IN_TWO_PULSE = 2'b11
  } apc_inmode_e;

  typedef enum logic [1:0] {
    MECH_ENC = 2'b00,
    MECH_OUT = 2'b01,
    MECH_PUL = 2'b10
  } apc_mech_sel_e;

  typedef enum logic [1:0] {
    DEFL_OUT_ENC = 2'b00,
    DEFL_OUT_PUL = 2'b01,
    DEFL_ENC_PUL = 2'b10
  } apc_defl_sel_e;

  typedef enum logic [1:0] {
    GP_OUT = 2'b00,
    GP_ENC = 2'b01,
    GP_PUL = 2'b10,
    GP_HALF = 2'b11
  } apc_gp_sel_e;

  typedef struct packed {
    logic up;
    logic dn;
  } apc_ev_s;

  typedef struct packed {
    apc_inmode_e mode;
    logic filt;
    logic rev;
    logic off;
    logic err_en;
  } apc_dec_cfg_s;

endpackage : apc_pkg

// ---- src/apc_axis_counters.sv ----
module apc_axis_counters (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pulse generator link
  input wire logic axis_start,
  input wire logic out_pulse,
  input wire logic out_dir_minus,
  input wire logic pos_override2_active,
  input wire logic pos_change_start_in,
  // Encoder and pulser phases
  input wire logic enc_phase_a,
  input wire logic enc_phase_b,
  input wire logic pulser_phase_a,
  input wire logic pulser_phase_b,
  // Interrupt
  output logic irq
);
  import apc_pkg::*;

  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic irq_r;
  logic aw_full_r;
  logic w_full_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  logic wr_hit;
  logic [31:0] target_r;
  logic pcs_en_r;
  logic [31:0] src_env_r;
  logic [31:0] inm_r;
  logic [IRQ_W-1:0] status_r;
  logic [IRQ_W-1:0] mask_r;
  logic [IRQ_W-1:0] status_clr;
  logic [31:0] pos_r;
  logic pcs_seen_r;
  logic pos_hold;
  logic half_r;
  logic [31:0] cmd_q;
  logic [31:0] mech_q;
  logic [15:0] defl_q;
  logic [31:0] gp_q;
  logic [31:0] defl_wide;
  logic [31:0] mode_merge;
  logic [31:0] defl_merge;
  logic [31:0] rd_data;
  logic rd_hit;
  apc_dec_cfg_s enc_cfg;
  apc_dec_cfg_s pul_cfg;
  apc_ev_s ev_out;
  apc_ev_s ev_enc;
  apc_ev_s ev_pul;
  apc_ev_s ev_half;
  apc_ev_s ev_mech;
  apc_ev_s ev_defl;
  apc_ev_s ev_gp;
  logic enc_err;
  logic pul_err;

  function automatic logic [31:0] apc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : apc_merge

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign irq = irq_r;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  // Address and data are caught independently; the write commits once both are held
  assign wr_go = aw_full_r & w_full_r & ~bvalid_r;
  assign defl_wide = {16'h0000, defl_q};
  // Merged words are named nets, since a function result cannot be indexed
  assign mode_merge = apc_merge({31'h0, pcs_en_r} << BIT_PCS_EN, wdata_r, wstrb_r);
  assign defl_merge = apc_merge(defl_wide, wdata_r, wstrb_r);

  always_ff @(posedge clock) begin
    if (srst) begin
      awready_r <= 1'b0;
      aw_full_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (s_axi_awvalid && awready_r) begin
      awready_r <= 1'b0;
      aw_full_r <= 1'b1;
      awaddr_r <= s_axi_awaddr & ADDR_ALIGN_MASK;
    end else begin
      if (wr_go) begin
        aw_full_r <= 1'b0;
      end
      awready_r <= ~aw_full_r & ~bvalid_r;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wready_r <= 1'b0;
      w_full_r <= 1'b0;
      wdata_r <= RST_WORD;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && wready_r) begin
      wready_r <= 1'b0;
      w_full_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else begin
      if (wr_go) begin
        w_full_r <= 1'b0;
      end
      wready_r <= ~w_full_r & ~bvalid_r;
    end
  end

  always_comb begin
    unique case (awaddr_r)
      OFF_TARGET, OFF_AXIS_MODE, OFF_SRC_ENV, OFF_INM_ENV, OFF_CMD, OFF_MECH,
      OFF_DEFL, OFF_GP, OFF_IRQ_STAT, OFF_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      target_r <= RST_WORD;
    end else if (wr_go && awaddr_r == OFF_TARGET) begin
      target_r <= apc_merge(target_r, wdata_r, wstrb_r);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pcs_en_r <= 1'b0;
      src_env_r <= RST_WORD;
      inm_r <= RST_WORD;
    end else if (wr_go) begin
      if (awaddr_r == OFF_AXIS_MODE) begin
        pcs_en_r <= mode_merge[BIT_PCS_EN];
      end
      if (awaddr_r == OFF_SRC_ENV) begin
        src_env_r <= apc_merge(src_env_r, wdata_r, wstrb_r) & SRC_ENV_MASK;
      end
      if (awaddr_r == OFF_INM_ENV) begin
        inm_r <= apc_merge(inm_r, wdata_r, wstrb_r) & INM_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Positioning counter
  // ----------------------------------------------------------------
  // The latch is cleared by each start, so every override waits afresh
  always_ff @(posedge clock) begin
    if (srst) begin
      pcs_seen_r <= 1'b0;
    end else if (axis_start) begin
      pcs_seen_r <= 1'b0;
    end else if (pos_change_start_in) begin
      pcs_seen_r <= 1'b1;
    end
  end

  assign pos_hold = pcs_en_r & pos_override2_active & ~pcs_seen_r;

  always_ff @(posedge clock) begin
    if (srst) begin
      pos_r <= RST_WORD;
    end else if (axis_start) begin
      pos_r <= target_r;
    end else if (out_pulse && !pos_hold) begin
      pos_r <= pos_r - 32'h00000001;
    end
  end

  // ----------------------------------------------------------------
  // Count sources
  // ----------------------------------------------------------------
  assign ev_out.up = out_pulse & ~out_dir_minus;
  assign ev_out.dn = out_pulse & out_dir_minus;
  assign ev_half.up = half_r;
  assign ev_half.dn = 1'b0;

  always_ff @(posedge clock) begin
    if (srst) begin
      half_r <= 1'b0;
    end else begin
      half_r <= ~half_r;
    end
  end

  assign enc_cfg.mode = apc_inmode_e'(inm_r[MODE_ENC_LSB +: 2]);
  assign enc_cfg.filt = inm_r[FILT_ENC];
  assign enc_cfg.rev = inm_r[REV_ENC];
  assign enc_cfg.off = inm_r[OFF_ENC_BIT];
  assign enc_cfg.err_en = inm_r[ERR_EN_ENC];
  assign pul_cfg.mode = apc_inmode_e'(inm_r[MODE_PUL_LSB +: 2]);
  assign pul_cfg.filt = inm_r[FILT_PUL];
  assign pul_cfg.rev = inm_r[REV_PUL];
  assign pul_cfg.off = inm_r[OFF_PUL_BIT];
  assign pul_cfg.err_en = inm_r[ERR_EN_PUL];

  apc_pair_decode u_enc_decode (
    .clock(clock),
    .srst(srst),
    .cfg(enc_cfg),
    .in_a(enc_phase_a),
    .in_b(enc_phase_b),
    .ev(ev_enc),
    .err(enc_err)
  );

  // Counters see the multiplied pulser events, never the pins
  apc_pair_decode u_pul_decode (
    .clock(clock),
    .srst(srst),
    .cfg(pul_cfg),
    .in_a(pulser_phase_a),
    .in_b(pulser_phase_b),
    .ev(ev_pul),
    .err(pul_err)
  );

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  always_comb begin
    unique case (apc_mech_sel_e'(src_env_r[CI2_LSB +: 2]))
      MECH_ENC: ev_mech = ev_enc;
      MECH_OUT: ev_mech = ev_out;
      MECH_PUL: ev_mech = ev_pul;
      default: ev_mech = '0;
    endcase
  end

  // Direction of each source is ignored: one count up, the other down
  always_comb begin
    unique case (apc_defl_sel_e'(src_env_r[CI3_LSB +: 2]))
      DEFL_OUT_ENC: begin
        ev_defl.up = ev_out.up | ev_out.dn;
        ev_defl.dn = ev_enc.up | ev_enc.dn;
      end
      DEFL_OUT_PUL: begin
        ev_defl.up = ev_out.up | ev_out.dn;
        ev_defl.dn = ev_pul.up | ev_pul.dn;
      end
      DEFL_ENC_PUL: begin
        ev_defl.up = ev_enc.up | ev_enc.dn;
        ev_defl.dn = ev_pul.up | ev_pul.dn;
      end
      default: ev_defl = '0;
    endcase
  end

  always_comb begin
    unique case (apc_gp_sel_e'(src_env_r[CI4_LSB +: 2]))
      GP_OUT: ev_gp = ev_out;
      GP_ENC: ev_gp = ev_enc;
      GP_PUL: ev_gp = ev_pul;
      GP_HALF: ev_gp = ev_half;
    endcase
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  apc_updown #(.W(32)) u_cmd (
    .clock(clock),
    .srst(srst),
    .load(wr_go && awaddr_r == OFF_CMD),
    .load_val(apc_merge(cmd_q, wdata_r, wstrb_r)),
    .ev(ev_out),
    .count(cmd_q)
  );

  apc_updown #(.W(32)) u_mech (
    .clock(clock),
    .srst(srst),
    .load(wr_go && awaddr_r == OFF_MECH),
    .load_val(apc_merge(mech_q, wdata_r, wstrb_r)),
    .ev(ev_mech),
    .count(mech_q)
  );

  apc_updown #(.W(16)) u_defl (
    .clock(clock),
    .srst(srst),
    .load(wr_go && awaddr_r == OFF_DEFL),
    .load_val(defl_merge[15:0]),
    .ev(ev_defl),
    .count(defl_q)
  );

  apc_updown #(.W(32)) u_gp (
    .clock(clock),
    .srst(srst),
    .load(wr_go && awaddr_r == OFF_GP),
    .load_val(apc_merge(gp_q, wdata_r, wstrb_r)),
    .ev(ev_gp),
    .count(gp_q)
  );

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign status_clr = (wr_go && awaddr_r == OFF_IRQ_STAT && wstrb_r[0]) ?
                      wdata_r[IRQ_W-1:0] : '0;

  // A new error in the clearing cycle stays set
  always_ff @(posedge clock) begin
    if (srst) begin
      status_r <= '0;
    end else begin
      status_r[IRQ_ENC_ERR] <= enc_err | (status_r[IRQ_ENC_ERR] & ~status_clr[IRQ_ENC_ERR]);
      status_r[IRQ_PUL_ERR] <= pul_err | (status_r[IRQ_PUL_ERR] & ~status_clr[IRQ_PUL_ERR]);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mask_r <= '0;
    end else if (wr_go && awaddr_r == OFF_IRQ_MASK && wstrb_r[0]) begin
      mask_r <= wdata_r[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr & ADDR_ALIGN_MASK)
      OFF_TARGET: rd_data = target_r;
      OFF_AXIS_MODE: rd_data = {31'h0, pcs_en_r} << BIT_PCS_EN;
      OFF_SRC_ENV: rd_data = src_env_r;
      OFF_INM_ENV: rd_data = inm_r;
      OFF_POS: rd_data = pos_r;
      OFF_CMD: rd_data = cmd_q;
      OFF_MECH: rd_data = mech_q;
      OFF_DEFL: rd_data = defl_wide;
      OFF_GP: rd_data = gp_q;
      OFF_IRQ_STAT: rd_data = {{(32 - IRQ_W){1'b0}}, status_r};
      OFF_IRQ_MASK: rd_data = {{(32 - IRQ_W){1'b0}}, mask_r};
      default: begin
        rd_data = RST_WORD;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= RST_WORD;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_data;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else begin
      if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
      arready_r <= ~rvalid_r;
    end
  end

endmodule : apc_axis_counters

// ---- src/apc_pair_decode.sv ----
module apc_pair_decode (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Configuration
  input wire apc_pkg::apc_dec_cfg_s cfg,
  // Raw phases
  input wire logic in_a,
  input wire logic in_b,
  // Decoded events
  output apc_pkg::apc_ev_s ev,
  output logic err
);
  import apc_pkg::*;

  localparam logic [1:0] FILT_LAST = 2'(FILT_CYCLES - 1);

  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] filt_r;
  logic [1:0] prev_r;
  logic [1:0] run_r [2];
  logic a;
  logic b;
  logic ch_a;
  logic ch_b;
  logic up;
  logic dn;
  apc_ev_s ev_nxt;
  logic err_nxt;

  // ----------------------------------------------------------------
  // Synchroniser and filter
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
    end else begin
      sync1_r <= {in_b, in_a};
      sync2_r <= sync1_r;
    end
  end

  // A new level is accepted only after three agreeing samples
  always_ff @(posedge clock) begin
    for (int i = 0; i < 2; i++) begin
      if (srst) begin
        run_r[i] <= 2'h0;
        filt_r[i] <= 1'b0;
      end else if (!cfg.filt || sync2_r[i] == filt_r[i]) begin
        run_r[i] <= 2'h0;
        filt_r[i] <= sync2_r[i];
      end else if (run_r[i] == FILT_LAST) begin
        run_r[i] <= 2'h0;
        filt_r[i] <= sync2_r[i];
      end else begin
        run_r[i] <= run_r[i] + 2'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      prev_r <= 2'h0;
    end else begin
      prev_r <= filt_r;
    end
  end

  // ----------------------------------------------------------------
  // Phase decoding
  // ----------------------------------------------------------------
  always_comb begin
    a = filt_r[0];
    b = filt_r[1];
    ch_a = a ^ prev_r[0];
    ch_b = b ^ prev_r[1];
    up = 1'b0;
    dn = 1'b0;
    err_nxt = cfg.err_en & ~cfg.off & ch_a & ch_b;
    // A double change has no defined direction, so it never counts
    if (!cfg.off && !(ch_a && ch_b)) begin
      unique case (cfg.mode)
        IN_QUAD1: begin
          up = ch_a & a & ~b;
          dn = ch_a & a & b;
        end
        IN_QUAD2: begin
          up = ch_a & (a ^ b);
          dn = ch_a & ~(a ^ b);
        end
        IN_QUAD4: begin
          up = (ch_a & (a ^ b)) | (ch_b & ~(a ^ b));
          dn = (ch_a & ~(a ^ b)) | (ch_b & (a ^ b));
        end
        IN_TWO_PULSE: begin
          up = ch_a & a;
          dn = ch_b & ~b;
        end
      endcase
    end
    ev_nxt.up = cfg.rev ? dn : up;
    ev_nxt.dn = cfg.rev ? up : dn;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ev <= '0;
      err <= 1'b0;
    end else begin
      ev <= ev_nxt;
      err <= err_nxt;
    end
  end

endmodule : apc_pair_decode

// ---- src/apc_updown.sv ----
module apc_updown #(
  parameter int unsigned W = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Software load
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // Count event
  input wire apc_pkg::apc_ev_s ev,
  // Value
  output logic [W-1:0] count
);
  import apc_pkg::*;

  // Load wins over a count in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      count <= W'(RST_WORD);
    end else if (load) begin
      count <= load_val;
    end else if (ev.up && !ev.dn) begin
      count <= count + W'(1);
    end else if (ev.dn && !ev.up) begin
      count <= count - W'(1);
    end
  end

endmodule : apc_updown

// ---- verif/apc_axis_counters_sva.sv ----
module apc_axis_counters_sva
  import apc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Write side
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read side
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----
  // Bus handshake checks
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not on time");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not on time");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_unmapped_read: assert property (s_ar_taken and
    (s_axi_araddr & ADDR_ALIGN_MASK) > OFF_IRQ_MASK |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
endmodule : apc_axis_counters_sva

bind apc_axis_counters apc_axis_counters_sva apc_axis_counters_sva_i (.*);

// ---- verif/apc_phase_src.sv ----
module apc_phase_src (
  // Pacing clock
  input wire logic clock,
  // Phase outputs
  output logic a,
  output logic b
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Phase pair source
  // ----
  initial begin
    a = 1'h0;
    b = 1'h0;
  end
  // Holding eight cycles keeps every level well past the input filter
  task automatic set(input logic na, input logic nb, input int k);
    @(posedge clock);
    a <= na;
    b <= nb;
    repeat (k) @(posedge clock);
  endtask : set
  task automatic steps(input int n, input logic up);
    repeat (n) begin
      if ((a == b) == up) set(~a, b, 8);
      else set(a, ~b, 8);
    end
  endtask : steps
endmodule : apc_phase_src

// ---- verif/test_axis_position_counters.sv ----
module test_axis_position_counters;
  timeunit 1ns;
  timeprecision 1ns;
  import apc_pkg::*;
  // ----
  // Wiring
  // ----
  logic clock = 1'h0;
  logic srst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, w0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, out_dir_minus = 1'h0;
  logic pos_override2_active = 1'h0;
  logic [2:0] strobe = 3'h0;
  wire axis_start = strobe[0];
  wire out_pulse = strobe[1];
  wire pos_change_start_in = strobe[2];
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic enc_phase_a, enc_phase_b, pulser_phase_a, pulser_phase_b;
  logic [31:0] mech_t [3] = '{32'h4, 32'h3, 32'h2};
  logic [31:0] defl_t [3] = '{32'hFFFF, 32'h1, 32'h2};
  logic [31:0] gp_t [3] = '{32'h3, 32'h4, 32'h2};
  int err_count = 0, samples_checked = 0, cyc = 0, rt, t0;
  apc_axis_counters apc_axis_counters_i (.*);
  apc_phase_src enc_i (.clock(clock), .a(enc_phase_a), .b(enc_phase_b));
  apc_phase_src pul_i (.clock(clock), .a(pulser_phase_a), .b(pulser_phase_b));
  initial forever #25 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    rsp = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    rt = cyc;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    v = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e);
  endtask : rdc
  task automatic pulse(input int i, input int n);
    repeat (n) begin
      @(posedge clock);
      strobe[i] <= 1'h1;
      @(posedge clock);
      strobe[i] <= 1'h0;
    end
  endtask : pulse
  task automatic tp(input int n, input logic up);
    repeat (n) begin
      enc_i.set(up, !up, 8);
      enc_i.set(1'h0, 1'h0, 8);
    end
  endtask : tp
  task automatic summarize;
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial begin
    #500000;
    err_count++;
    $display("ERROR %0t: timeout", $time);
    summarize();
  end
  // ----
  // Sequence
  // ----
  initial begin
    repeat (5) @(posedge clock);
    srst <= 1'h0;
    rdc(OFF_SRC_ENV, 32'h0);
    rd(8'h40);
    chk(rsp, RESP_SLVERR);
    wr(OFF_TARGET, 32'h5);
    pulse(0, 1);
    pulse(1, 3);
    rdc(OFF_POS, 32'h2);
    out_dir_minus <= 1'h1;
    pulse(1, 1);
    out_dir_minus <= 1'h0;
    rdc(OFF_POS, 32'h1);
    rdc(OFF_CMD, 32'h2);
    wr(OFF_POS, 32'h9);
    chk(rsp, RESP_SLVERR);
    wr(OFF_AXIS_MODE, 32'h4000);
    pos_override2_active <= 1'h1;
    pulse(0, 1);
    pulse(1, 2);
    rdc(OFF_POS, 32'h5);
    pulse(2, 1);
    pulse(1, 2);
    rdc(OFF_POS, 32'h3);
    wr(OFF_INM_ENV, 32'h01200000);
    for (int c = 0; c < 3; c++) begin
      wr(OFF_SRC_ENV, 32'h1500 * c);
      wr(OFF_MECH, 32'h0);
      wr(OFF_DEFL, 32'h0);
      wr(OFF_GP, 32'h0);
      pulse(1, 3);
      enc_i.steps(4, 1'h1);
      pul_i.steps(4, 1'h1);
      rdc(OFF_MECH, mech_t[c]);
      rdc(OFF_DEFL, defl_t[c]);
      rdc(OFF_GP, gp_t[c]);
    end
    rdc(OFF_CMD, 32'hF);
    wr(OFF_SRC_ENV, 32'h3000);
    rd(OFF_GP);
    t0 = rt;
    w0 = v;
    // An even gap between samples makes the half-rate count exact
    repeat (9) @(posedge clock);
    while ((cyc + 1 - t0) % 2 != 0) @(posedge clock);
    rd(OFF_GP);
    chk(v - w0, (rt - t0) / 2);
    wr(OFF_SRC_ENV, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr(OFF_INM_ENV, 32'h00100000 * m);
      wr(OFF_MECH, 32'h0);
      if (m < 3) enc_i.steps(4, 1'h1);
      else tp(3, 1'h1);
      if (m == 3) tp(1, 1'h0);
      rdc(OFF_MECH, (m < 3) ? (32'h1 << m) : 32'h2);
    end
    wr(OFF_INM_ENV, 32'h00600000);
    wr(OFF_MECH, 32'h0);
    enc_i.steps(4, 1'h1);
    rdc(OFF_MECH, 32'hFFFFFFFC);
    wr(OFF_INM_ENV, 32'h00340000);
    wr(OFF_MECH, 32'h0);
    enc_i.set(1'h1, 1'h0, 1);
    enc_i.set(1'h0, 1'h0, 8);
    tp(1, 1'h1);
    rdc(OFF_MECH, 32'h1);
    wr(OFF_INM_ENV, 32'h00030000);
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_MECH, 32'h0);
    pul_i.set(1'h1, 1'h1, 8);
    pul_i.set(1'h0, 1'h0, 8);
    chk(irq, 1'h0);
    enc_i.set(1'h1, 1'h1, 8);
    enc_i.set(1'h0, 1'h0, 8);
    chk(irq, 1'h1);
    rdc(OFF_MECH, 32'h0);
    wr(OFF_IRQ_MASK, 32'h0);
    rdc(OFF_IRQ_STAT, 32'h3);
    chk(irq, 1'h0);
    wr(OFF_IRQ_STAT, 32'h3);
    rdc(OFF_IRQ_STAT, 32'h0);
    summarize();
  end
endmodule : test_axis_position_counters
